// File: core/sram_host.sv
// Host controller that reads and writes a 1K by 4 static RAM over its pins
// Notes on behaviour
// - Write starts with select and strobe low
// - Write ends when either line rises
// - Data held stable around terminating edge
// - Address stable before strobe falls, after rise
// - Read data valid after both access delays
`timescale 1ns/1ns
module sram_host
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Request port
    input wire logic i_req,
    input wire logic i_req_write,
    input wire logic [sram_host_pkg::ADDR_W-1:0] i_req_addr,
    input wire logic [sram_host_pkg::DATA_W-1:0] i_req_wdata,
    output logic o_busy,
    output logic o_done,
    output logic [sram_host_pkg::DATA_W-1:0] o_rdata,
    // Memory pins
    output logic [sram_host_pkg::ADDR_W-1:0] o_mem_addr,
    output logic o_mem_cs_n,
    output logic o_mem_we_n,
    output logic [sram_host_pkg::DATA_W-1:0] o_mem_dq,
    output logic o_mem_dq_oe,
    input wire logic [sram_host_pkg::DATA_W-1:0] i_mem_dq
);

    sram_host_pkg::state_t state_reg, state_next;
    logic [sram_host_pkg::CNT_W-1:0] cnt_reg, cnt_next;
    logic write_reg, write_next;
    logic busy_reg, busy_next;
    logic done_reg, done_next;
    logic [sram_host_pkg::DATA_W-1:0] rdata_reg, rdata_next;
    logic [sram_host_pkg::ADDR_W-1:0] addr_reg, addr_next;
    logic cs_n_reg, cs_n_next;
    logic we_n_reg, we_n_next;
    logic [sram_host_pkg::DATA_W-1:0] dq_reg, dq_next;
    logic dq_oe_reg, dq_oe_next;
    logic [sram_host_pkg::DATA_W-1:0] dq_s1_reg, dq_s2_reg, dq_s3_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Read data synchroniser, three stages; only s2 and s3 are compared
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            dq_s1_reg <= '0;
            dq_s2_reg <= '0;
            dq_s3_reg <= '0;
        end
        else
        begin
            dq_s1_reg <= i_mem_dq;
            dq_s2_reg <= dq_s1_reg;
            dq_s3_reg <= dq_s2_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer next state
    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        write_next = write_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        rdata_next = rdata_reg;
        addr_next = addr_reg;
        cs_n_next = cs_n_reg;
        we_n_next = we_n_reg;
        dq_next = dq_reg;
        dq_oe_next = dq_oe_reg;
        case (state_reg)
            sram_host_pkg::ST_IDLE:
            begin
                if (i_req)
                begin
                    // Address set a cycle before any strobe falls
                    addr_next = i_req_addr;
                    write_next = i_req_write;
                    dq_next = i_req_wdata;
                    busy_next = 1'b1;
                    cnt_next = '0;
                    state_next = sram_host_pkg::ST_SETUP;
                end
            end
            sram_host_pkg::ST_SETUP:
            begin
                // Select drops with the strobe; for writes both go low together
                cs_n_next = 1'b0;
                we_n_next = ~write_reg;
                dq_oe_next = write_reg;
                state_next = sram_host_pkg::ST_STROBE;
            end
            sram_host_pkg::ST_STROBE:
            begin
                cnt_next = cnt_reg + 1'b1;
                // Write strobe stays low until the count passes WRITE_CYC, with no sync lag added
                if (write_reg && cnt_reg >= sram_host_pkg::CNT_W'(sram_host_pkg::WRITE_CYC))
                begin
                    we_n_next = 1'b1;
                    state_next = sram_host_pkg::ST_CAPTURE;
                end
                // Read word counts only once the last two stages agree
                else if (!write_reg && dq_s2_reg == dq_s3_reg &&
                         cnt_reg >= sram_host_pkg::CNT_W'(sram_host_pkg::ACCESS_CYC
                                                          + sram_host_pkg::SYNC_CYC))
                begin
                    rdata_next = dq_s3_reg;
                    cs_n_next = 1'b1;
                    state_next = sram_host_pkg::ST_CAPTURE;
                end
            end
            sram_host_pkg::ST_CAPTURE:
            begin
                // Data and address held one cycle past the rising strobe
                cs_n_next = 1'b1;
                dq_oe_next = 1'b0;
                cnt_next = '0;
                state_next = sram_host_pkg::ST_RECOVER;
            end
            sram_host_pkg::ST_RECOVER:
            begin
                // Let the device release the bus before another access
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg >= sram_host_pkg::CNT_W'(sram_host_pkg::RELEASE_CYC))
                begin
                    busy_next = 1'b0;
                    done_next = 1'b1;
                    state_next = sram_host_pkg::ST_IDLE;
                end
            end
            default:
            begin
                state_next = sram_host_pkg::ST_IDLE;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_reg <= sram_host_pkg::ST_IDLE;
            cnt_reg <= '0;
            write_reg <= 1'b0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            rdata_reg <= '0;
            addr_reg <= '0;
            cs_n_reg <= 1'b1;
            we_n_reg <= 1'b1;
            dq_reg <= '0;
            dq_oe_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            write_reg <= write_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
            rdata_reg <= rdata_next;
            addr_reg <= addr_next;
            cs_n_reg <= cs_n_next;
            we_n_reg <= we_n_next;
            dq_reg <= dq_next;
            dq_oe_reg <= dq_oe_next;
        end
    end

    // Outputs straight from flops
    assign o_busy = busy_reg;
    assign o_done = done_reg;
    assign o_rdata = rdata_reg;
    assign o_mem_addr = addr_reg;
    assign o_mem_cs_n = cs_n_reg;
    assign o_mem_we_n = we_n_reg;
    assign o_mem_dq = dq_reg;
    assign o_mem_dq_oe = dq_oe_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the pin sequence
    property p_write_needs_select;
        @(posedge i_clk_sys) disable iff (i_rst)
        !o_mem_we_n |-> !o_mem_cs_n;
    endproperty
    a_write_needs_select: assert property (p_write_needs_select)
        else $error("strobe low without select");

    property p_addr_stable;
        @(posedge i_clk_sys) disable iff (i_rst)
        (!o_mem_cs_n || !$past(o_mem_cs_n)) |-> $stable(o_mem_addr);
    endproperty
    a_addr_stable: assert property (p_addr_stable)
        else $error("address moved during access");

    property p_data_hold;
        @(posedge i_clk_sys) disable iff (i_rst)
        $rose(o_mem_we_n) |-> o_mem_dq_oe && $stable(o_mem_dq) ##1 $stable(o_mem_dq);
    endproperty
    a_data_hold: assert property (p_data_hold)
        else $error("write data not held at strobe rise");

    property p_write_len;
        @(posedge i_clk_sys) disable iff (i_rst)
        $fell(o_mem_we_n) |-> !o_mem_we_n [*8];
    endproperty
    a_write_len: assert property (p_write_len)
        else $error("write pulse too short");

    property p_read_no_drive;
        @(posedge i_clk_sys) disable iff (i_rst)
        // The cycle after the strobe rises still holds write data on purpose
        (o_mem_we_n && $past(o_mem_we_n) && !o_mem_cs_n) |-> !o_mem_dq_oe;
    endproperty
    a_read_no_drive: assert property (p_read_no_drive)
        else $error("host drives bus during read");

    property p_done_after;
        @(posedge i_clk_sys) disable iff (i_rst)
        (state_reg == sram_host_pkg::ST_SETUP) |-> ##[3:80] o_done;
    endproperty
    a_done_after: assert property (p_done_after)
        else $error("access did not finish in time");

    property p_released;
        @(posedge i_clk_sys) disable iff (i_rst)
        o_done |-> o_mem_cs_n && o_mem_we_n && !o_mem_dq_oe;
    endproperty
    a_released: assert property (p_released)
        else $error("pins not idle at completion");

    property p_idle_pins;
        @(posedge i_clk_sys) disable iff (i_rst)
        !o_busy |-> o_mem_cs_n;
    endproperty
    a_idle_pins: assert property (p_idle_pins)
        else $error("select low while idle");

    c_write: cover property (@(posedge i_clk_sys) $rose(o_mem_we_n));
    c_read: cover property (@(posedge i_clk_sys) o_done && !write_reg);
    c_back: cover property (@(posedge i_clk_sys) o_done && i_req);

endmodule

// File: core/sram_host_pkg.sv
// Constants shared by the static RAM access controller
package sram_host_pkg;
    // Geometry of the memory that is driven
    localparam int ADDR_W = 10;
    localparam int DATA_W = 4;
    // Access times in ns, from the slowest speed grade
    localparam int T_ACCESS_NS = 450;
    localparam int T_WRITE_NS = 250;
    localparam int T_DATA_SETUP_NS = 200;
    localparam int T_DESELECT_NS = 100;
    localparam int CLK_PERIOD_NS = 10;
    // Least times round up to whole cycles
    localparam int ACCESS_CYC = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_CYC = (T_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETUP_CYC = (T_DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RELEASE_CYC = (T_DESELECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Cycles of lag through the read data synchroniser
    localparam int SYNC_CYC = 3;
    localparam int CNT_W = 8;
    // Controller sequence, Gray coded along the usual path except the two-bit step from recover back to idle
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_STROBE = 3'b011,
        ST_CAPTURE = 3'b010,
        ST_RECOVER = 3'b110
    } state_t;
endpackage

// File: tb/sram_dev_model.sv
// Behavioural model of the 1K by 4 static RAM beside the host
`timescale 1ns/1ns
module sram_dev_model
#(
    parameter int P_ACC_NS = 450,
    parameter int P_ON_NS = 20
)
(
    // Memory pins
    input wire logic [9:0] i_addr,
    input wire logic i_cs_n,
    input wire logic i_we_n,
    input wire logic [3:0] i_dq,
    output logic [3:0] o_dq = 4'h0,
    output logic o_dq_oe,
    output logic o_standby
);
    logic [3:0] mem [0:1023];
    logic [9:0] row;
    logic wr_on;
    logic rd_on;
    int gen = 0;
    ////////////////////////////////////////////////////////////////////////
    // Pin address is folded before it reaches the array
    assign row = {i_addr[0], i_addr[1], i_addr[2], i_addr[9:3]};
    assign wr_on = ~i_cs_n & ~i_we_n;
    assign rd_on = ~i_cs_n & i_we_n;
    assign o_standby = i_cs_n;
    // Slow turn-on, so a one-cycle read gap never drives
    assign #(P_ON_NS, 0) o_dq_oe = rd_on;
    // Data taken when the overlap ends, whichever line rises first
    always @(negedge wr_on)
        mem[row] = i_dq;
    // Lines toggle on every change, so stale data is never mistaken
    always @(row or rd_on)
    begin
        gen = gen + 1;
        o_dq = ~o_dq;
        fork
            settle(gen);
        join_none
    end
    // A newer change cancels an older pending result
    task automatic settle(input int g);
        #(P_ACC_NS);
        if (g == gen && rd_on)
            o_dq = mem[row];
    endtask
endmodule

// File: tb/test_sram_host.sv
// Self-checking bench for the static RAM host controller
`timescale 1ns/1ns
module test_sram_host;
    typedef struct packed {logic rd; logic [3:0] d;} note_t;
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    logic i_req = 1'b0;
    logic i_req_write = 1'b0;
    logic [9:0] i_req_addr = 10'h000;
    logic [3:0] i_req_wdata = 4'h0;
    logic o_busy, o_done, o_mem_cs_n, o_mem_we_n, o_mem_dq_oe, dev_oe, standby;
    logic [3:0] o_rdata, o_mem_dq, dev_dq, wire_dq;
    logic [9:0] o_mem_addr, prev_addr;
    logic prev_cs_n = 1'b1;
    logic [3:0] shadow [0:1023];
    note_t notes[$];
    note_t seen;
    int n_mismatch = 0;
    int n_tests = 0;
    ////////////////////////////////////////////////////////////////////////
    // Clock and shared data lines
    always #5 i_clk_sys = ~i_clk_sys;
    assign wire_dq = o_mem_dq_oe ? o_mem_dq : dev_dq;
    sram_host u_sram_host (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_req(i_req),
        .i_req_write(i_req_write), .i_req_addr(i_req_addr), .i_req_wdata(i_req_wdata),
        .o_busy(o_busy), .o_done(o_done), .o_rdata(o_rdata), .o_mem_addr(o_mem_addr),
        .o_mem_cs_n(o_mem_cs_n), .o_mem_we_n(o_mem_we_n), .o_mem_dq(o_mem_dq),
        .o_mem_dq_oe(o_mem_dq_oe), .i_mem_dq(wire_dq));
    sram_dev_model u_sram_dev_model (.i_addr(o_mem_addr), .i_cs_n(o_mem_cs_n),
        .i_we_n(o_mem_we_n), .i_dq(o_mem_dq), .o_dq(dev_dq), .o_dq_oe(dev_oe),
        .o_standby(standby));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
        n_tests++;
        if (exp !== got)
        begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            n_mismatch++;
        end
    endtask
    task automatic wrap_up();
        $display("Checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Waits for idle, notes the expectation, then pulses the request
    task automatic do_op(input logic wr, input logic [9:0] a, input logic [3:0] d);
        note_t n;
        int k;
        k = 0;
        while (o_busy !== 1'b0 && k < 300)
        begin
            @(posedge i_clk_sys);
            #1;
            k++;
        end
        if (k >= 300)
            check("idle wait", 10'h000, 10'(k));
        n.rd = ~wr;
        n.d = shadow[a];
        if (wr)
            shadow[a] = d;
        notes.push_back(n);
        i_req = 1'b1;
        i_req_write = wr;
        i_req_addr = a;
        i_req_wdata = d;
        @(posedge i_clk_sys);
        #1;
        i_req = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Mid-cycle watch of results and pins, where everything has settled
    always @(negedge i_clk_sys)
    begin
        if (o_done === 1'b1 && notes.size() == 0)
            check("spare done", 10'h000, 10'h001);
        else if (o_done === 1'b1)
        begin
            seen = notes.pop_front();
            if (seen.rd)
                check("rdata", {6'h00, seen.d}, {6'h00, o_rdata});
        end
        // Busy must cover every selected cycle; idle leaves the part in standby
        if (o_mem_cs_n === 1'b0)
            check("busy", 10'h001, {9'h000, o_busy});
        if (o_busy === 1'b0)
            check("standby", 10'h001, {9'h000, standby});
        if (o_mem_cs_n === 1'b0 && prev_cs_n === 1'b0)
            check("addr hold", prev_addr, o_mem_addr);
        if (o_mem_we_n === 1'b0)
            check("write qual", 10'h001, {9'h000, o_mem_dq_oe & ~o_mem_cs_n});
        if (o_mem_dq_oe === 1'b1)
            check("dq clash", 10'h000, {9'h000, dev_oe});
        prev_addr = o_mem_addr;
        prev_cs_n = o_mem_cs_n;
    end
    // Some 60 accesses of at most 65 cycles; five times that is a hang
    initial
    begin
        #200000;
        n_mismatch++;
        wrap_up();
    end
    // Main sequence
    initial
    begin
        logic [9:0] addrs[$];
        void'($urandom(32'h856A6DC7));
        repeat (3) @(posedge i_clk_sys);
        #1;
        i_rst = 1'b0;
        // Walking ones with distinct data expose any folded address bit
        for (int i = 0; i < 10; i++)
            addrs.push_back(10'h001 << i);
        addrs.push_back(10'h000);
        addrs.push_back(10'h3FF);
        for (int i = 0; i < 8; i++)
            addrs.push_back(10'($urandom));
        foreach (addrs[j])
            do_op(1'b1, addrs[j], (j < 12) ? 4'(j) : 4'($urandom));
        foreach (addrs[j])
            do_op(1'b0, addrs[j], 4'h0);
        foreach (addrs[j])
            do_op(1'b0, addrs[j], 4'h0);
        // A request while busy must leave no trace
        do_op(1'b1, 10'h155, 4'hA);
        @(posedge i_clk_sys);
        #1;
        i_req = 1'b1;
        i_req_wdata = 4'h5;
        @(posedge i_clk_sys);
        #1;
        i_req = 1'b0;
        do_op(1'b0, 10'h155, 4'h0);
        repeat (200)
            if (notes.size() != 0)
                @(posedge i_clk_sys);
        // An access that never finished must not pass quietly
        check("notes left", 10'h000, 10'(notes.size()));
        wrap_up();
    end
endmodule
